// ===== logic/gpb_pair_cfg.sv
// Group B pin-pair configuration register with APB slave and pin logic.
// Assumes pin inputs synchronous to pclk; pad combines out and oe.
// Summary of operation
// - Register resets to 8000h; bit 15 read-only, always one.
// - Bits 14:12 are plain read/write spare storage without effect.
// - Pin one input: format zero reads static level, one reads PWM decode.
// - Pin zero input: format bit selects static or PWM-decoded level likewise.
// - Outputs always drive a static level; no PWM output waveform.
// - Direction bit clear makes input, set makes output; bit 9 pin one, 8 pin zero.
// - Two-bit time base picks decode period of 16, 64, 256 or 1024 clocks.
// - Output data bit sets driven level while output; ignored while input.
`timescale 1ns/1ps
`default_nettype none
module gpb_pair_cfg
  import gpb_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pin one
  input wire logic group_b_pin_one_in,
  output logic group_b_pin_one_out,
  output logic group_b_pin_one_oe,
  // Pin zero
  input wire logic group_b_pin_zero_in,
  output logic group_b_pin_zero_out,
  output logic group_b_pin_zero_oe,
  // Resolved input levels
  output logic pin_one_level,
  output logic pin_zero_level
);
  logic [15:0] cfg_q;
  logic [31:0] prdata_q;
  logic [1:0] lvl_q;
  logic access;
  logic hit_cfg;
  logic hit_stat;
  logic [1:0] dec_level;

  gpb_pin_if p1 ();
  gpb_pin_if p0 ();

  assign access = psel && penable;
  assign hit_cfg = (paddr == GPB_CFG_ADDR);
  assign hit_stat = (paddr == GPB_STAT_ADDR);

  // Field views
  logic pin_one_input_format;
  logic pin_zero_input_format;
  logic pin_one_direction;
  logic pin_zero_direction;
  logic [1:0] pin_one_decode_period;
  logic [1:0] pin_zero_decode_period;
  logic pin_one_output_level;
  logic pin_zero_output_level;

  assign pin_one_input_format = cfg_q[GPB_FMT1_BIT];
  assign pin_zero_input_format = cfg_q[GPB_FMT0_BIT];
  assign pin_one_direction = cfg_q[GPB_DIR1_BIT];
  assign pin_zero_direction = cfg_q[GPB_DIR0_BIT];
  assign pin_one_decode_period = cfg_q[GPB_TB1_LSB +: GPB_TB_W];
  assign pin_zero_decode_period = cfg_q[GPB_TB0_LSB +: GPB_TB_W];
  assign pin_one_output_level = cfg_q[GPB_DAT1_BIT];
  assign pin_zero_output_level = cfg_q[GPB_DAT0_BIT];

  // Writable bits; top bit forced to one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= GPB_CFG_RESET;
    end else if (access && pwrite && hit_cfg) begin
      cfg_q <= (pwdata[15:0] & GPB_WMASK) | GPB_CFG_RESET;
    end
  end

  // Decoders run only for inputs with format one
  assign p1.decode_en = !pin_one_direction && pin_one_input_format;
  assign p1.period_sel = pin_one_decode_period;
  assign p1.pin_in = group_b_pin_one_in;
  assign p0.decode_en = !pin_zero_direction && pin_zero_input_format;
  assign p0.period_sel = pin_zero_decode_period;
  assign p0.pin_in = group_b_pin_zero_in;
  assign dec_level = {p1.level, p0.level};

  gpb_pwm_decoder u_dec1 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(p1)
  );

  gpb_pwm_decoder u_dec0 (
    .pclk(pclk),
    .presetn(presetn),
    .pin(p0)
  );

  // Input level per pin; held low while the pin is an output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_q <= 2'h0;
    end else begin
      lvl_q[1] <= pin_one_direction ? 1'b0 :
                  (pin_one_input_format ? dec_level[1] : group_b_pin_one_in);
      lvl_q[0] <= pin_zero_direction ? 1'b0 :
                  (pin_zero_input_format ? dec_level[0] : group_b_pin_zero_in);
    end
  end

  assign pin_one_level = lvl_q[1];
  assign pin_zero_level = lvl_q[0];

  // Static drive only; format bit ignored on outputs
  assign group_b_pin_one_oe = pin_one_direction;
  assign group_b_pin_zero_oe = pin_zero_direction;
  assign group_b_pin_one_out = pin_one_direction & pin_one_output_level;
  assign group_b_pin_zero_out = pin_zero_direction & pin_zero_output_level;

  // Read data registered in setup phase, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (hit_cfg) begin
        prdata_q <= {16'h0000, cfg_q};
      end else if (hit_stat) begin
        prdata_q <= {30'h0000_0000, lvl_q};
      end else begin
        prdata_q <= '0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access && !(hit_cfg || (hit_stat && !pwrite));
endmodule
`default_nettype wire

// ===== logic/gpb_pkg.sv
// Package for the group B pin-pair configuration block.
// Assumes an APB slave with 32-bit data and a 40 MHz pclk.
package gpb_pkg;
  localparam logic [7:0] GPB_CFG_INDEX = 8'hC1;
  localparam logic [11:0] GPB_CFG_ADDR = 12'h0_304;
  localparam logic [11:0] GPB_STAT_ADDR = 12'h0_308;
  localparam logic [15:0] GPB_CFG_RESET = 16'h8000;
  localparam int GPB_RSVD_BIT = 15;
  localparam int GPB_SPARE_HI_MSB = 14;
  localparam int GPB_SPARE_HI_LSB = 12;
  localparam int GPB_FMT1_BIT = 11;
  localparam int GPB_FMT0_BIT = 10;
  localparam int GPB_DIR1_BIT = 9;
  localparam int GPB_DIR0_BIT = 8;
  localparam int GPB_TB1_LSB = 6;
  localparam int GPB_TB0_LSB = 4;
  localparam int GPB_SPARE_LO_LSB = 2;
  localparam int GPB_DAT1_BIT = 1;
  localparam int GPB_DAT0_BIT = 0;
  localparam int GPB_TB_W = 2;
  localparam int GPB_CNT_W = 11;
  localparam logic [GPB_CNT_W-1:0] GPB_PERIOD_16 = 11'h010;
  localparam logic [GPB_CNT_W-1:0] GPB_PERIOD_64 = 11'h040;
  localparam logic [GPB_CNT_W-1:0] GPB_PERIOD_256 = 11'h100;
  localparam logic [GPB_CNT_W-1:0] GPB_PERIOD_1024 = 11'h400;
  localparam logic [15:0] GPB_WMASK = 16'h7FFF;
endpackage

// ===== logic/gpb_pin_if.sv
// Interface carrying one pin's configuration and sensed level.
// Assumes one pclk domain shared by both sides.
`timescale 1ns/1ps
`default_nettype none
interface gpb_pin_if;
  logic decode_en;
  logic [1:0] period_sel;
  logic pin_in;
  logic level;
  modport ctrl (output decode_en, output period_sel, output pin_in, input level);
  modport dec (input decode_en, input period_sel, input pin_in, output level);
endinterface
`default_nettype wire

// ===== logic/gpb_pwm_decoder.sv
// PWM input decoder for one pin.
// Assumes the pin input is already synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module gpb_pwm_decoder
  import gpb_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin side
  gpb_pin_if.dec pin
);
  logic [GPB_CNT_W-1:0] period;
  logic [GPB_CNT_W-1:0] cnt_q;
  logic [GPB_CNT_W-1:0] high_q;
  logic level_q;
  logic [GPB_TB_W-1:0] sel_q;
  logic last;

  always_comb begin
    case (pin.period_sel)
      2'h0: period = GPB_PERIOD_16;
      2'h1: period = GPB_PERIOD_64;
      2'h2: period = GPB_PERIOD_256;
      default: period = GPB_PERIOD_1024;
    endcase
  end

  assign last = (cnt_q == period - 11'h001);

  // Window restarts when the period changes or decoding is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      high_q <= '0;
      sel_q <= '0;
    end else if (!pin.decode_en || sel_q != pin.period_sel) begin
      cnt_q <= '0;
      high_q <= '0;
      sel_q <= pin.period_sel;
    end else if (last) begin
      cnt_q <= '0;
      high_q <= '0;
    end else begin
      cnt_q <= cnt_q + 11'h001;
      high_q <= high_q + {10'h000, pin.pin_in};
    end
  end

  // High when high time exceeds half the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
    end else if (pin.decode_en && sel_q == pin.period_sel && last) begin
      level_q <= ((high_q + {10'h000, pin.pin_in}) > (period >> 1));
    end
  end

  assign pin.level = level_q;
endmodule
`default_nettype wire

// ===== dv/gpb_pin_drv.sv
// Model of a driver outside one pin: static level or PWM.
// Assumes pclk from the bench; period n, high count h.
`timescale 1ns/1ps
`default_nettype none
module gpb_pin_drv (
  // Clock
  input wire logic pclk,
  // Waveform choice
  input wire logic pwm,
  input wire logic lvl,
  input wire logic [10:0] n,
  input wire logic [10:0] h,
  // Pin
  output logic pin = 1'b0
);
  logic [10:0] c = 11'h000;
  always @(posedge pclk) c <= (c + 11'h001 >= n) ? 11'h000 : c + 11'h001;
  // Every window of n samples holds exactly h highs
  always @(posedge pclk) pin <= pwm ? (c < h) : lvl;
endmodule
`default_nettype wire

// ===== dv/gpb_pair_monitor.sv
// Checker on the pin-pair block ports.
// Bound to gpb_pair_cfg after the module.
`timescale 1ns/1ps
`default_nettype none
module gpb_pair_monitor
  import gpb_pkg::*;
(
  input wire logic pclk, presetn, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic group_b_pin_one_oe, group_b_pin_one_out, pin_one_level,
  input wire logic group_b_pin_zero_oe, group_b_pin_zero_out, pin_zero_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence cfg_wr; psel && penable && pwrite && paddr == GPB_CFG_ADDR; endsequence
  sequence cfg_rd; psel && !penable && !pwrite && paddr == GPB_CFG_ADDR; endsequence
  sequence odd_wr; psel && penable && pwrite && paddr != GPB_CFG_ADDR; endsequence
  one_dir_a: assert property (cfg_wr |=> group_b_pin_one_oe == $past(pwdata[9]))
    else $error("pin one direction wrong");
  zero_dir_a: assert property (cfg_wr |=> group_b_pin_zero_oe == $past(pwdata[8]))
    else $error("pin zero direction wrong");
  one_out_a: assert property (cfg_wr |=>
    group_b_pin_one_out == ($past(pwdata[9]) & $past(pwdata[1]))) else $error("pin one level");
  zero_out_a: assert property (cfg_wr |=>
    group_b_pin_zero_out == ($past(pwdata[8]) & $past(pwdata[0]))) else $error("pin zero level");
  rsvd_read_a: assert property (cfg_rd |=> prdata[31:15] == 17'h0_0001)
    else $error("top bits read wrong");
  one_quiet_a: assert property (group_b_pin_one_oe [*2] |-> !pin_one_level)
    else $error("pin one level while output");
  zero_quiet_a: assert property (group_b_pin_zero_oe [*2] |-> !pin_zero_level)
    else $error("pin zero level while output");
  odd_wr_a: assert property (odd_wr |=> $stable(group_b_pin_one_oe) &&
    $stable(group_b_pin_zero_oe)) else $error("stray write took effect");
endmodule
bind gpb_pair_cfg gpb_pair_monitor gpb_pair_monitor_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .group_b_pin_one_oe, .group_b_pin_one_out,
  .pin_one_level, .group_b_pin_zero_oe, .group_b_pin_zero_out, .pin_zero_level);
`default_nettype wire

// ===== dv/test_gpb_pair_cfg.sv
// Bench for the pin-pair configuration block.
// APB master tasks and two pin models on one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_gpb_pair_cfg;
  import gpb_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pwm = 0, lvl = 0;
  logic [11:0] paddr = 12'h0_000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [10:0] n = 11'h010, h1 = 11'h000, h0 = 11'h000;
  logic pready, pslverr, err, p1, p0, o1, e1, o0, e0, l1, l0;
  int mismatches = 0, n_checks = 0, cyc = 0;
  always #12.5 pclk = ~pclk;
  gpb_pair_cfg gpb_pair_cfg_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .group_b_pin_one_in(p1), .group_b_pin_one_out(o1),
    .group_b_pin_one_oe(e1), .group_b_pin_zero_in(p0), .group_b_pin_zero_out(o0),
    .group_b_pin_zero_oe(e0), .pin_one_level(l1), .pin_zero_level(l0));
  gpb_pin_drv gpb_pin_drv_inst (.pclk, .pwm, .lvl, .n, .h(h1), .pin(p1));
  gpb_pin_drv gpb_pin_drv_inst_b (.pclk, .pwm, .lvl, .n, .h(h0), .pin(p0));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict;
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, GPB_CFG_ADDR, 0);
    chk("reset value", rd, 32'h0000_8000);
    $display("test reset done");
    apb(1, GPB_CFG_ADDR, 32'hFFFF_FFFF);
    apb(0, GPB_CFG_ADDR, 0);
    chk("all ones", rd, 32'h0000_FFFF);
    chk("static outputs", {e1, o1, e0, o0}, 4'hF);
    apb(1, GPB_CFG_ADDR, 32'h0000_0300);
    apb(0, GPB_CFG_ADDR, 0);
    chk("top bit kept", rd, 32'h0000_8300);
    chk("low outputs", {e1, o1, e0, o0}, 4'hA);
    apb(1, 12'h0_300, 32'hFFFF_FFFF);
    chk("stray error", err, 1'b1);
    apb(0, GPB_CFG_ADDR, 0);
    chk("stray ignored", rd, 32'h0000_8300);
    $display("test outputs done");
    apb(1, GPB_CFG_ADDR, 32'h0000_7003);
    lvl <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, GPB_STAT_ADDR, 0);
    chk("static status", rd, 32'h0000_0003);
    chk("ready high", pready, 1'b1);
    apb(0, GPB_CFG_ADDR, 0);
    chk("spare kept", rd, 32'h0000_F003);
    chk("static inputs", {e1, o1, e0, o0, l1, l0}, 6'h03);
    $display("test static done");
    pwm <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      n <= 11'h010 << (2 * k);
      h1 <= (11'h008 << (2 * k)) + 11'h001;
      h0 <= 11'h008 << (2 * k);
      apb(1, GPB_CFG_ADDR, 32'h0000_0C00 | (k << 6) | (k << 4));
      repeat (3 * (16 << (2 * k)) + 8) @(posedge pclk);
      chk("pwm decode", {l1, l0}, 2'b10);
    end
    apb(0, GPB_STAT_ADDR, 0);
    chk("pwm status", rd, 32'h0000_0002);
    $display("test pwm done");
    print_verdict;
  end
endmodule
`default_nettype wire
